// File: core/sdd_top.sv
// Strap decoder and default-loaded management registers on APB
`timescale 1ns/1ps

module sdd_top (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Board strap pins
   input  wire logic [6:0]  config_strap_pins,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Shared transmit-disable / soft-reset pin
   input  wire logic        tx_disable_softrst_pin,
   output logic             tx_disable,
   output logic             soft_reset_n,
   // Shared present / clock pin
   input  wire logic        eeprom_released,
   output logic             module_present_out,
   output logic             module_present_oe,
   output logic             mac_ref_clock_out,
   // Shared loss / detect pin
   input  wire logic        signal_detect_pin_in,
   input  wire logic        sig_detect_src,
   output logic             signal_detect_pin_out,
   output logic             signal_detect_pin_oe,
   output logic             rx_loss_of_signal,
   output logic             signal_detect,
   // Register bank contents and modes for the core
   output logic      [15:0] adv_reg,
   output logic      [15:0] gig_ctrl_reg,
   output logic             module_mode,
   output logic             signal_detect_pin_is_output,
   output logic             module_agreement_protocol,
   output logic             defaults_loaded
);

   // ==========================================================
   // Synchronisers for the strap and shared pins

   logic [6:0] strap_s;
   logic [1:0] pins_s;

   sdd_sync #(
      .W        (sdd_pkg::STRAP_W)
   ) u_strap_sync (
      .core_clk (core_clk),
      .async_in (config_strap_pins),
      .sync_out (strap_s)
   );

   sdd_sync #(
      .W        (2)
   ) u_pin_sync (
      .core_clk (core_clk),
      .async_in ({signal_detect_pin_in, tx_disable_softrst_pin}),
      .sync_out (pins_s)
   );

   // ==========================================================
   // Loader sequence: hold in reset, load once, then run

   sdd_pkg::sdd_load_e state_r;
   sdd_pkg::sdd_load_e state_nxt;

   // Next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         sdd_pkg::ST_HOLD: begin
            state_nxt = sdd_pkg::ST_LOAD;
         end
         sdd_pkg::ST_LOAD: begin
            state_nxt = sdd_pkg::ST_RUN;
         end
         sdd_pkg::ST_RUN: begin
            state_nxt = sdd_pkg::ST_RUN;
         end
         default: begin
            state_nxt = sdd_pkg::ST_HOLD;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= sdd_pkg::ST_HOLD;
      end else begin
         state_r <= state_nxt;
      end
   end

   logic load;
   assign load = (state_r == sdd_pkg::ST_LOAD);

   // ==========================================================
   // Strap capture, one time after reset release

   logic [6:0] strap_r;

   // Captured once; later pin changes are ignored
   always_ff @(posedge core_clk) begin
      if (reset) begin
         strap_r <= 7'h00;
      end else if (state_r == sdd_pkg::ST_HOLD) begin
         strap_r <= strap_s;
      end
   end

   // ==========================================================
   // Default decode from the captured straps

   logic [1:0]  adv_code;
   logic [1:0]  fc_code;
   logic        view_fiber;
   logic        mod_dis;
   logic [15:0] adv_dflt;
   logic [15:0] gig_dflt;
   logic        e21_dflt;
   logic        e19_dflt;

   assign adv_code   = strap_r[sdd_pkg::ADV_LO +: 2];
   assign fc_code    = strap_r[sdd_pkg::FC_LO +: 2];
   assign view_fiber = strap_r[sdd_pkg::VIEW_BIT];
   assign mod_dis    = strap_r[sdd_pkg::MODDIS_BIT];

   // Base advertisement default
   always_comb begin
      adv_dflt = sdd_pkg::A4_SELECTOR;
      if (view_fiber) begin
         adv_dflt[sdd_pkg::A4_XFD] = 1'b1;
         adv_dflt[sdd_pkg::A4_FC37_LO +: 2] = fc_code;
      end else begin
         if (adv_code != sdd_pkg::ADV_1G_FD) begin
            adv_dflt[sdd_pkg::A4_10HD]  = 1'b1;
            adv_dflt[sdd_pkg::A4_10FD]  = 1'b1;
            adv_dflt[sdd_pkg::A4_100HD] = 1'b1;
            adv_dflt[sdd_pkg::A4_100FD] = 1'b1;
         end
         adv_dflt[sdd_pkg::A4_FC28_LO +: 2] = fc_code;
      end
   end

   // Gigabit control default
   always_comb begin
      gig_dflt = 16'h0000;
      unique case (adv_code)
         sdd_pkg::ADV_ALL: begin
            gig_dflt[sdd_pkg::G9_1GHD] = 1'b1;
            gig_dflt[sdd_pkg::G9_1GFD] = 1'b1;
         end
         sdd_pkg::ADV_NO1GHD: begin
            gig_dflt[sdd_pkg::G9_1GFD] = 1'b1;
         end
         sdd_pkg::ADV_10_100: begin
            gig_dflt = 16'h0000;
         end
         sdd_pkg::ADV_1G_FD: begin
            gig_dflt[sdd_pkg::G9_1GFD] = 1'b1;
         end
      endcase
   end

   // Mode bits
   assign e21_dflt = ~mod_dis;
   assign e19_dflt = mod_dis & strap_r[sdd_pkg::SDDIR_BIT];

   // ==========================================================
   // APB decode

   logic        setup;
   logic        access;
   logic        wr_en;
   logic        hit;
   logic        hit_r;
   logic [15:0] wmask;

   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign wr_en  = access & pwrite & hit_r;
   assign wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // Address hit
   always_comb begin
      unique case (paddr)
         sdd_pkg::ADDR_ADV,
         sdd_pkg::ADDR_GIG,
         sdd_pkg::ADDR_E21,
         sdd_pkg::ADDR_E19,
         sdd_pkg::ADDR_STAT: hit = 1'b1;
         default:            hit = 1'b0;
      endcase
   end

   // Zero-wait answer, error on unmapped or status write
   assign pready  = 1'b1;
   assign pslverr = access & (~hit_r | (pwrite &
                    (paddr == sdd_pkg::ADDR_STAT)));

   // Decode held from the setup cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hit_r <= 1'b0;
      end else if (setup) begin
         hit_r <= hit;
      end
   end

   // ==========================================================
   // Register bank: defaults on load, software writes after

   logic [15:0] adv_r;
   logic [15:0] gig_r;
   logic        e21_r;
   logic        e19_r;

   // Base advertisement register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adv_r <= 16'h0000;
      end else if (load) begin
         adv_r <= adv_dflt;
      end else if (wr_en && paddr == sdd_pkg::ADDR_ADV) begin
         adv_r <= (adv_r & ~wmask) | (pwdata[15:0] & wmask);
      end
   end

   // Gigabit control register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         gig_r <= 16'h0000;
      end else if (load) begin
         gig_r <= gig_dflt;
      end else if (wr_en && paddr == sdd_pkg::ADDR_GIG) begin
         gig_r <= (gig_r & ~wmask) | (pwdata[15:0] & wmask);
      end
   end

   // Extended module-mode bit
   always_ff @(posedge core_clk) begin
      if (reset) begin
         e21_r <= 1'b0;
      end else if (load) begin
         e21_r <= e21_dflt;
      end else if (wr_en && paddr == sdd_pkg::ADDR_E21 && pstrb[1]) begin
         e21_r <= pwdata[sdd_pkg::E21_MOD_BIT];
      end
   end

   // Extended signal-detect direction bit
   always_ff @(posedge core_clk) begin
      if (reset) begin
         e19_r <= 1'b0;
      end else if (load) begin
         e19_r <= e19_dflt;
      end else if (wr_en && paddr == sdd_pkg::ADDR_E19 && pstrb[0]) begin
         e19_r <= pwdata[sdd_pkg::E19_DIR_BIT];
      end
   end

   // ==========================================================
   // Read data, captured in the setup cycle

   logic [31:0] rd_nxt;

   // Read mux
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         sdd_pkg::ADDR_ADV: rd_nxt[15:0] = adv_r;
         sdd_pkg::ADDR_GIG: rd_nxt[15:0] = gig_r;
         sdd_pkg::ADDR_E21: rd_nxt[sdd_pkg::E21_MOD_BIT] = e21_r;
         sdd_pkg::ADDR_E19: rd_nxt[sdd_pkg::E19_DIR_BIT] = e19_r;
         sdd_pkg::ADDR_STAT: begin
            rd_nxt[6:0] = strap_r;
            rd_nxt[sdd_pkg::STAT_LOADED]  = defaults_loaded;
            rd_nxt[sdd_pkg::STAT_MODMODE] = e21_r;
         end
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read data register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= rd_nxt;
      end
   end

   // ==========================================================
   // Outputs to the core

   // Registered mode and status outputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         defaults_loaded           <= 1'b0;
         module_agreement_protocol <= 1'b0;
      end else begin
         defaults_loaded           <= load | defaults_loaded;
         module_agreement_protocol <= e21_r;
      end
   end

   assign adv_reg          = adv_r;
   assign gig_ctrl_reg     = gig_r;
   assign module_mode      = e21_r;
   assign signal_detect_pin_is_output = e19_r;

   // ==========================================================
   // Shared pin steering

   sdd_shared_pins u_pins (
      .core_clk              (core_clk),
      .reset                 (reset),
      .module_mode           (e21_r),
      .signal_detect_pin_is_output      (e19_r),
      .tx_disable_pin_s           (pins_s[0]),
      .loss_pin_s            (pins_s[1]),
      .eeprom_released       (eeprom_released),
      .sig_detect_src        (sig_detect_src),
      .tx_disable            (tx_disable),
      .soft_reset_n          (soft_reset_n),
      .rx_loss_of_signal     (rx_loss_of_signal),
      .signal_detect         (signal_detect),
      .module_present_out    (module_present_out),
      .module_present_oe     (module_present_oe),
      .mac_ref_clock_out     (mac_ref_clock_out),
      .signal_detect_pin_out (signal_detect_pin_out),
      .signal_detect_pin_oe  (signal_detect_pin_oe)
   );

endmodule

// File: core/sdd_pkg.sv
// Constants, field layouts and types of the strap default decoder
package sdd_pkg;

   // ==========================================================
   // Strap bus layout
   localparam int STRAP_W     = 7;
   localparam int ADV_LO      = 0;  // Advertisement field, 2 bits
   localparam int FC_LO       = 2;  // Flow-control field, 2 bits
   localparam int VIEW_BIT    = 4;  // 1 = fiber-style register view
   localparam int MODDIS_BIT  = 5;  // 1 = module mode disabled
   localparam int SDDIR_BIT   = 6;  // Signal-detect direction

   // Advertisement strap codes
   localparam logic [1:0] ADV_ALL    = 2'h0;
   localparam logic [1:0] ADV_NO1GHD = 2'h1;
   localparam logic [1:0] ADV_10_100 = 2'h2;
   localparam logic [1:0] ADV_1G_FD  = 2'h3;

   // ==========================================================
   // Management register fields
   localparam int REG_W        = 16;
   localparam int A4_10HD      = 5;
   localparam int A4_10FD      = 6;
   localparam int A4_100HD     = 7;
   localparam int A4_100FD     = 8;
   localparam int A4_FC28_LO   = 10;
   localparam int A4_FC37_LO   = 7;
   localparam int A4_XFD       = 5;
   localparam logic [15:0] A4_SELECTOR = 16'h0001;
   localparam int G9_1GHD      = 8;
   localparam int G9_1GFD      = 9;
   localparam int E21_MOD_BIT  = 15;
   localparam int E19_DIR_BIT  = 1;
   localparam int STAT_LOADED  = 8;
   localparam int STAT_MODMODE = 9;

   // ==========================================================
   // APB map
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [11:0] ADDR_ADV  = 12'h000;
   localparam logic [11:0] ADDR_GIG  = 12'h004;
   localparam logic [11:0] ADDR_E21  = 12'h008;
   localparam logic [11:0] ADDR_E19  = 12'h00c;
   localparam logic [11:0] ADDR_STAT = 12'h010;

   // Loader sequence
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_LOAD = 3'b010,
      ST_RUN  = 3'b100
   } sdd_load_e;

endpackage

// File: core/sdd_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdd_sync #(
   parameter int W = 1
) (
   // Clock
   input  wire logic         core_clk,
   // Asynchronous input and synchronised output
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   // Free running so the chain is settled when reset ends
   always_ff @(posedge core_clk) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
   end

endmodule

// File: core/sdd_shared_pins.sv
// Mode-dependent steering of the shared pins
`timescale 1ns/1ps
module sdd_shared_pins (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Mode controls from the register bank
   input  wire logic module_mode,
   input  wire logic signal_detect_pin_is_output,
   // Synchronised pin levels and core sources
   input  wire logic tx_disable_pin_s,
   input  wire logic loss_pin_s,
   input  wire logic eeprom_released,
   input  wire logic sig_detect_src,
   // Decoded pin functions
   output logic      tx_disable,
   output logic      soft_reset_n,
   output logic      rx_loss_of_signal,
   output logic      signal_detect,
   // Shared present/clock pin
   output logic      module_present_out,
   output logic      module_present_oe,
   output logic      mac_ref_clock_out,
   // Shared loss/detect pin drive
   output logic      signal_detect_pin_out,
   output logic      signal_detect_pin_oe
);

   // Transmit-disable / soft-reset pin
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tx_disable   <= 1'b0;
         soft_reset_n <= 1'b1;
      end else begin
         tx_disable   <= module_mode & tx_disable_pin_s;
         soft_reset_n <= module_mode | tx_disable_pin_s;
      end
   end

   // Present pin pulled low after release, or clock select
   always_ff @(posedge core_clk) begin
      if (reset) begin
         module_present_out <= 1'b0;
         module_present_oe  <= 1'b0;
         mac_ref_clock_out  <= 1'b0;
      end else begin
         module_present_out <= 1'b0;
         module_present_oe  <= ~module_mode | eeprom_released;
         mac_ref_clock_out  <= ~module_mode;
      end
   end

   // Loss/detect pin meaning and direction
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rx_loss_of_signal     <= 1'b0;
         signal_detect         <= 1'b0;
         signal_detect_pin_out <= 1'b0;
         signal_detect_pin_oe  <= 1'b0;
      end else begin
         rx_loss_of_signal <= module_mode & loss_pin_s;
         signal_detect     <= ~module_mode &
                              (signal_detect_pin_is_output ? sig_detect_src
                                                : loss_pin_s);
         signal_detect_pin_out <= sig_detect_src;
         signal_detect_pin_oe  <= ~module_mode & signal_detect_pin_is_output;
      end
   end

endmodule

// File: sim/sdd_asserts.sv
// Port-level assertions for the strap default decoder
`timescale 1ns/1ps
module sdd_asserts (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Straps and pins
   input wire logic [6:0]  config_strap_pins,
   input wire logic        tx_disable_softrst_pin,
   input wire logic        eeprom_released,
   input wire logic        signal_detect_pin_in,
   // Decoded pin functions
   input wire logic        tx_disable,
   input wire logic        soft_reset_n,
   input wire logic        rx_loss_of_signal,
   input wire logic        module_present_out,
   input wire logic        module_present_oe,
   input wire logic        mac_ref_clock_out,
   input wire logic        signal_detect_pin_oe,
   // Register bank view
   input wire logic [15:0] adv_reg,
   input wire logic [15:0] gig_ctrl_reg,
   input wire logic        module_mode,
   input wire logic        signal_detect_pin_is_output,
   input wire logic        module_agreement_protocol,
   input wire logic        defaults_loaded
);
   // ==========================================================
   // Common timing
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // Load moment and settled modes
   sequence s_load;
      $rose(defaults_loaded);
   endsequence
   sequence s_mod;
      (module_mode && defaults_loaded)[*4];
   endsequence
   sequence s_sa;
      (!module_mode && defaults_loaded)[*4];
   endsequence

   // ==========================================================
   // Defaults at load
   AST_MODE_DFLT: assert property (s_load |->
      module_mode == !config_strap_pins[5]) else $error("mode default");
   AST_GIG_NO1GHD: assert property ((s_load and
      config_strap_pins[1:0] == 2'h1) |-> gig_ctrl_reg[9:8] == 2'h2)
      else $error("gig default code 01");
   // Fiber view reuses bits 8:5 for duplex and flow, so skip them there
   AST_ADV_1GFD: assert property ((s_load and
      config_strap_pins[1:0] == 2'h3) |-> gig_ctrl_reg[9:8] == 2'h2
      && (config_strap_pins[4] || adv_reg[8:5] == 4'h0))
      else $error("code 11 default");
   AST_FLOW_TP: assert property ((s_load and
      !config_strap_pins[4]) |-> adv_reg[11:10] == config_strap_pins[3:2])
      else $error("flow bits twisted view");
   AST_FLOW_FIB: assert property ((s_load and
      config_strap_pins[4]) |-> adv_reg[8:7] == config_strap_pins[3:2])
      else $error("flow bits fiber view");
   AST_SDIR_DFLT: assert property (s_load |->
      signal_detect_pin_is_output == (config_strap_pins[6] & config_strap_pins[5]))
      else $error("detect direction default");

   // ==========================================================
   // Shared pins
   AST_TX_DISABLE: assert property (s_mod |->
      tx_disable == $past(tx_disable_softrst_pin, 3) && soft_reset_n)
      else $error("transmit disable pin");
   AST_SRST: assert property (s_sa |->
      soft_reset_n == $past(tx_disable_softrst_pin, 3) && !tx_disable)
      else $error("soft reset pin");
   AST_PRESENT: assert property (s_mod |->
      module_present_oe == $past(eeprom_released) && !module_present_out)
      else $error("present pin");
   AST_CLKSEL: assert property (s_sa |->
      mac_ref_clock_out && module_present_oe) else $error("clock pin");
   AST_LOS: assert property (s_mod |->
      rx_loss_of_signal == $past(signal_detect_pin_in, 3)
      && !signal_detect_pin_oe) else $error("loss of signal pin");
   AST_PROTO: assert property (defaults_loaded[*2] |->
      module_agreement_protocol == $past(module_mode))
      else $error("management protocol mode");
endmodule

bind sdd_top sdd_asserts u_chk (.*);

// File: sim/sdd_board.sv
// Board straps and module host facing the decoder
`timescale 1ns/1ps
module sdd_board (
   // Bench controls
   input  wire logic [6:0] strap_val,
   input  wire logic       tx_disable_lvl,
   input  wire logic       loss_lvl,
   // Device drive of the loss/detect pin
   input  wire logic       pin_out,
   input  wire logic       pin_oe,
   // Board pins into the device
   output logic      [6:0] config_strap_pins,
   output logic            tx_disable_softrst_pin,
   output logic            signal_detect_pin_in
);
   // Strap resistors give fixed levels
   assign config_strap_pins = strap_val;
   assign tx_disable_softrst_pin = tx_disable_lvl;
   // Host drives the pin only while the device leaves it
   assign signal_detect_pin_in = pin_oe ? pin_out : loss_lvl;
endmodule

// File: sim/strap_default_decoder_tb.sv
// Self-checking bench for the strap default decoder
`timescale 1ns/1ps
module strap_default_decoder_tb;
   // ==========================================================
   // Signals
   logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [6:0]  config_strap_pins, strap_val, s;
   logic        tx_disable_softrst_pin, eeprom_released, signal_detect_pin_in;
   logic        sig_detect_src, tx_disable, soft_reset_n, lvl, er, m;
   logic        module_present_out, module_present_oe, mac_ref_clock_out;
   logic        signal_detect_pin_out, signal_detect_pin_oe;
   logic        rx_loss_of_signal, signal_detect, module_mode;
   logic        signal_detect_pin_is_output, module_agreement_protocol;
   logic        defaults_loaded;
   logic [15:0] adv_reg, gig_ctrl_reg;
   int          n_errors, check_count;

   // Design and board
   sdd_top u_dut (.*);
   sdd_board u_brd (
      .strap_val            (strap_val),
      .tx_disable_lvl            (lvl),
      .loss_lvl             (lvl),
      .pin_out              (signal_detect_pin_out),
      .pin_oe               (signal_detect_pin_oe),
      .config_strap_pins    (config_strap_pins),
      .tx_disable_softrst_pin    (tx_disable_softrst_pin),
      .signal_detect_pin_in (signal_detect_pin_in)
   );

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ==========================================================
   // Reference model
   function automatic int exp_adv(logic [6:0] v);
      int a;
      a = 1;
      if (v[4]) begin
         a = a | 32'h20 | (int'(v[3:2]) << 7);
      end else begin
         if (v[1:0] != 2'h3) a = a | 32'h1e0;
         a = a | (int'(v[3:2]) << 10);
      end
      return a;
   endfunction
   function automatic int exp_gig(logic [1:0] c);
      int t[4] = '{32'h300, 32'h200, 32'h0, 32'h200};
      return t[c];
   endfunction

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic do_reset(input logic [6:0] v);
      strap_val <= v;
      reset <= 1'b1;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      end_sim;
   end

   // ==========================================================
   // Main sequence
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata} = '0;
      {lvl, eeprom_released, sig_detect_src} = '0;
      pstrb = 4'hf;
      strap_val = 7'h0;
      n_errors = 0;
      check_count = 0;
      void'($urandom(32'hdb16));
      for (int i = 0; i < 8; i++) begin
         s = 7'($urandom);
         s[1:0] = 2'(i);
         s[5] = i[2];
         m = !s[5];
         do_reset(s);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, exp_adv(s));
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, exp_gig(s[1:0]));
         apb(1'b0, 12'h008, 32'h0);
         chk(rd[15], !s[5]);
         apb(1'b0, 12'h00c, 32'h0);
         chk(rd[1], s[6] & s[5]);
         chk({gig_ctrl_reg, adv_reg},
             {16'(exp_gig(s[1:0])), 16'(exp_adv(s))});
         for (int j = 0; j < 2; j++) begin
            lvl <= 1'(j);
            eeprom_released <= 1'(j);
            sig_detect_src <= 1'(j);
            repeat (5) @(posedge core_clk);
            chk({tx_disable, soft_reset_n, rx_loss_of_signal,
                 module_present_oe, module_present_out, mac_ref_clock_out,
                 signal_detect, signal_detect_pin_oe, signal_detect_pin_out,
                 module_agreement_protocol, module_mode, signal_detect_pin_is_output,
                 defaults_loaded, pready},
                {m & lvl, m | lvl, m & lvl, m ? lvl : 1'b1, 1'b0, !m,
                 !m & lvl, !m & s[6], lvl, m, m, s[6] & s[5],
                 2'h3});
         end
      end
      // Writes override, straps ignored until the next reset
      apb(1'b1, 12'h000, 32'h0000_0c21);
      strap_val <= ~s;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000_0c21);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, {22'h0, !s[5], 1'b1, 1'b0, s});
      // Software takes over the mode and direction bits
      apb(1'b1, 12'h008, 32'h0000_8000);
      apb(1'b1, 12'h00c, 32'h0000_0002);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_8000);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0000_0002);
      chk({tx_disable, mac_ref_clock_out}, 2'h2);
      do_reset(s);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, exp_adv(s));
      // Unmapped read and status write are refused
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, 12'h010, 32'hffff_ffff);
      chk(er, 1'b1);
      end_sim;
   end
endmodule
